/* File: hw/sac_pkg.sv */
// Shared constants and types of the serial attenuator control block
package sac_pkg;
  localparam int unsigned FRAME_BITS  = 16;
  localparam int unsigned BYTE_BITS   = 8;
  localparam int unsigned NUM_CHAN    = 3;
  localparam logic [7:0]  ADDR_CH0    = 8'h00;
  localparam logic [7:0]  ADDR_CH1    = 8'h01;
  localparam logic [7:0]  ADDR_CH2    = 8'h02;
  localparam logic [7:0]  MUTE_FIRST  = 8'h4F;
  localparam logic [7:0]  MUTE_CODE   = 8'h4F;

  typedef struct packed {
    logic       mute;
    logic [7:0] tap;
  } sac_chan_t;

  localparam sac_chan_t CHAN_RESET = '{mute: 1'b1, tap: MUTE_CODE};

  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] level;
  } sac_frame_t;
endpackage : sac_pkg

/* File: hw/sac_core.sv */
// Serial shift, latch and decode logic of the three-channel attenuator
`timescale 1ns/1ps
`default_nettype none

module sac_core
  import sac_pkg::*;
#(
  parameter int unsigned N_BITS = FRAME_BITS
)(
  // System
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  clk_en,
  // Serial pins
  input  wire logic                  ser_clk,
  input  wire logic                  ser_load,
  input  wire logic                  ser_din,
  output logic                       ser_dout,
  // Channel controls
  output sac_chan_t [NUM_CHAN-1:0]   chan_set,
  output logic      [NUM_CHAN-1:0]   chan_connect,
  output logic                       frame_latched
);

  logic [2:0]        sync1_r;
  logic [2:0]        sync2_r;
  logic              sclk_prev_r;
  logic              load_prev_r;
  logic [N_BITS-1:0] shift_r;
  logic [N_BITS-1:0] shift_nxt;
  sac_frame_t        latch_r;
  sac_chan_t [NUM_CHAN-1:0] chan_r;
  logic              latched_r;
  logic              dout_r;
  sac_chan_t [NUM_CHAN-1:0] chan_nxt;
  sac_chan_t         lvl_set;

  // Pin idle levels: data low, strobe high, clock low
  localparam logic [2:0] SYNC_IDLE = 3'h2;

  wire sclk_s = sync2_r[0];
  wire load_s = sync2_r[1];
  wire din_s  = sync2_r[2];
  wire sclk_rise = sclk_s & ~sclk_prev_r;
  wire shift_en  = sclk_rise & ~load_s;
  wire load_rise = load_s & ~load_prev_r;

  // Decode of the latched frame
  function automatic logic [NUM_CHAN-1:0] sac_addr_dec(input logic [7:0] a);
    sac_addr_dec = {a == ADDR_CH2, a == ADDR_CH1, a == ADDR_CH0};
  endfunction : sac_addr_dec

  wire [NUM_CHAN-1:0] chan_hit = sac_addr_dec(latch_r.addr);
  wire                lvl_mute = latch_r.level >= MUTE_FIRST;

  assign shift_nxt = {shift_r[N_BITS-2:0], din_s};

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      // Idle levels, so no false strobe or clock edge follows reset
      sync1_r     <= SYNC_IDLE;
      sync2_r     <= SYNC_IDLE;
      sclk_prev_r <= 1'b0;
      load_prev_r <= 1'b1;
    end
    else if (clk_en)
    begin
      sync1_r     <= {ser_din, ser_load, ser_clk};
      sync2_r     <= sync1_r;
      sclk_prev_r <= sclk_s;
      load_prev_r <= load_s;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      shift_r <= '0;
      dout_r  <= 1'b0;
    end
    else if (clk_en && shift_en)
    begin
      shift_r <= shift_nxt;
      dout_r  <= shift_r[N_BITS-1];
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      latch_r   <= '0;
      latched_r <= 1'b0;
    end
    else if (clk_en)
    begin
      latched_r <= load_rise;
      if (load_rise)
        latch_r <= shift_r[FRAME_BITS-1:0];
    end
  end

  // New setting from the latched level byte
  assign lvl_set = '{mute: lvl_mute, tap: lvl_mute ? MUTE_CODE : latch_r.level};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_CHAN; gi++)
    begin : g_chan
      // Only the addressed channel takes the new setting
      assign chan_nxt[gi]     = (latched_r && chan_hit[gi]) ? lvl_set : chan_r[gi];
      assign chan_connect[gi] = ~chan_r[gi].mute;
      // Muted channel reports the mute code
      chk_mute_tap: assert property (@(posedge clk) disable iff (!rst_n)
        chan_r[gi].mute |-> chan_r[gi].tap == MUTE_CODE)
        else $error("muted channel tap wrong");
    end
  endgenerate

  always_ff @(posedge clk)
  begin
    if (!rst_n)
      chan_r <= {NUM_CHAN{CHAN_RESET}};
    else if (clk_en)
      chan_r <= chan_nxt;
  end

  assign chan_set      = chan_r;
  assign ser_dout      = dout_r;
  assign frame_latched = latched_r;

  // Power-up muting
  chk_reset_mute: assert property (@(posedge clk)
    $rose(rst_n) |-> chan_r[0].mute && chan_r[1].mute && chan_r[2].mute)
    else $error("channels not muted after reset");
  // Latch follows the strobe rise
  chk_latch_rise: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && load_rise |=> latch_r == $past(shift_r))
    else $error("frame not latched on strobe rise");
  // No shifting while strobe high
  chk_shift_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && load_s |=> $stable(shift_r))
    else $error("shift while strobe high");
  // Serial out carries old top bit
  chk_dout_msb: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && shift_en |=> ser_dout == $past(shift_r[N_BITS-1]))
    else $error("serial out wrong bit");
  // Addressed channel updates
  chk_chan_update: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && latched_r && chan_hit[0] |=> chan_r[0].mute == $past(lvl_mute))
    else $error("channel 0 not updated");
  // Mute threshold
  chk_mute_level: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && latched_r && chan_hit[1] && latch_r.level == 8'h4E
      |=> !chan_r[1].mute && chan_r[1].tap == 8'h4E)
    else $error("0x4E should not mute");
  // Unknown address ignored
  chk_addr_miss: assert property (@(posedge clk) disable iff (!rst_n)
    latched_r && chan_hit == 3'h0 |=> $stable(chan_r))
    else $error("unknown address changed a channel");
  // Settings hold without a frame
  chk_hold_idle: assert property (@(posedge clk) disable iff (!rst_n)
    !latched_r |=> $stable(chan_r))
    else $error("setting changed without frame");
  // Mute disconnects
  chk_mute_open: assert property (@(posedge clk) disable iff (!rst_n)
    chan_r[2].mute |-> !chan_connect[2])
    else $error("muted channel connected");
  // No false edge right after reset
  chk_sync_quiet: assert property (@(posedge clk)
    $rose(rst_n) |-> !load_rise && !sclk_rise)
    else $error("false pin edge after reset");
  // Latch pulse lasts one cycle
  chk_latch_pulse: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && latched_r |=> !latched_r)
    else $error("latch pulse longer than one cycle");
  // Addressed channel takes the level as its tap
  chk_tap_load: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && latched_r && chan_hit[2] && !lvl_mute
      |=> !chan_r[2].mute && chan_r[2].tap == $past(latch_r.level))
    else $error("channel 2 tap not loaded");
  // Bits enter at the bottom, MSB first
  chk_shift_in: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && shift_en |=> shift_r == {$past(shift_r[N_BITS-2:0]), $past(din_s)})
    else $error("shifted bit wrong");
  // Clock enable low freezes state
  chk_freeze_all: assert property (@(posedge clk) disable iff (!rst_n)
    !clk_en |=> $stable(shift_r) && $stable(latch_r) && $stable(chan_r))
    else $error("state moved while clock enable low");
  // No shift without a clock edge
  chk_shift_only: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !shift_en |=> $stable(shift_r))
    else $error("shift without serial clock edge");
  // Serial out holds between shifts
  chk_dout_hold: assert property (@(posedge clk) disable iff (!rst_n)
    clk_en && !shift_en |=> $stable(ser_dout))
    else $error("serial out moved without shift");

endmodule : sac_core

`default_nettype wire

/* File: verif/sac_host.sv */
// Host model that shifts frames into the attenuator
`timescale 1ns/1ps
`default_nettype none
module sac_host (
  // Link
  input  wire logic clk,
  input  wire logic ser_dout,
  output logic      ser_clk,
  output logic      ser_load,
  output logic      ser_din
);
  initial
  begin
    ser_clk  = 1'b0;
    ser_load = 1'b1;
    ser_din  = 1'b0;
  end
  // Shift n bits MSB first, gathering ser_dout after each shift; lo low keeps strobe high
  task automatic xfer(input logic [31:0] d, input int n, input logic lo, output logic [31:0] got);
    got      = 32'h0;
    ser_load = ~lo;
    ser_din  = d[n-1];
    repeat (2) @(negedge clk);
    for (int i = n - 1; i >= 0; i--)
    begin
      ser_clk = 1'b1;
      repeat (4) @(negedge clk);
      ser_clk = 1'b0;
      repeat (2) @(negedge clk);
      got     = {got[30:0], ser_dout};
      ser_din = (i > 0) ? d[(i>0)?i-1:0] : ~d[0];
      repeat (2) @(negedge clk);
    end
    ser_load = 1'b1;
    repeat (8) @(negedge clk);
  endtask : xfer
endmodule : sac_host
`default_nettype wire

/* File: verif/tb_top.sv */
// Self-checking bench of the serial attenuator control block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sac_pkg::*;
  logic                     clk, rst_n, ser_clk, ser_load, ser_din, ser_dout, frame_latched;
  logic                     clk_en;
  sac_chan_t [NUM_CHAN-1:0] chan_set;
  logic      [NUM_CHAN-1:0] chan_connect;
  sac_chan_t                exp_ch [NUM_CHAN];
  logic      [31:0]         got;
  int                       errors, n_compared, n_lat, n_frames, cycles;
  sac_core uut (.clk(clk), .rst_n(rst_n), .clk_en(clk_en), .ser_clk(ser_clk),
    .ser_load(ser_load), .ser_din(ser_din), .ser_dout(ser_dout), .chan_set(chan_set),
    .chan_connect(chan_connect), .frame_latched(frame_latched));
  sac_host host (.clk(clk), .ser_dout(ser_dout), .ser_clk(ser_clk), .ser_load(ser_load),
    .ser_din(ser_din));
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Counted at the falling edge, where outputs are settled
  always @(negedge clk)
  begin
    cycles++;
    if (frame_latched === 1'b1)
      n_lat++;
    if (cycles == 20000)
    begin
      errors++;
      end_sim();
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] seen);
    n_compared++;
    if (seen !== exp)
    begin
      errors++;
      $display("CHECK FAILED %s exp %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic chk_chans();
    for (int c = 0; c < NUM_CHAN; c++)
    begin
      chk("chan_set", 32'(exp_ch[c]), 32'(chan_set[c]));
      chk("chan_connect", {31'h0, ~exp_ch[c].mute}, {31'h0, chan_connect[c]});
    end
  endtask : chk_chans
  task automatic send(input logic [7:0] a, input logic [7:0] l);
    host.xfer({16'h0, a, l}, 16, 1'b1, got);
    n_frames++;
    if (a < 8'h03)
      exp_ch[a] = (l >= MUTE_FIRST) ? CHAN_RESET : sac_chan_t'{1'b0, l};
    chk_chans();
  endtask : send
  task automatic t_taps();
    logic [7:0] lv [6] = '{8'h00, 8'h4E, 8'h11, 8'h2A, 8'hFF, 8'h4F};
    for (int i = 0; i < 6; i++)
      send(8'(i % 3), lv[i]);
    $display("test taps done");
  endtask : t_taps
  task automatic t_bad_addr();
    send(8'h03, 8'h00);
    send(8'h80, 8'h00);
    send(8'hFF, 8'h00);
    $display("test bad_addr done");
  endtask : t_bad_addr
  task automatic t_chain();
    host.xfer(32'h0120_0233, 32, 1'b1, got);
    n_frames++;
    exp_ch[2] = sac_chan_t'{1'b0, 8'h33};
    chk("chain out", 32'hFF00_0120, got);
    chk_chans();
    $display("test chain done");
  endtask : t_chain
  task automatic t_held();
    host.xfer(32'h0000_A5C3, 16, 1'b0, got);
    chk("held out", 32'h0, got);
    chk_chans();
    send(8'h00, 8'h05);
    chk("after held", 32'h0000_0233, got);
    $display("test held done");
  endtask : t_held
  task automatic t_freeze();
    clk_en = 1'b0;
    host.xfer({16'h0, ADDR_CH1, 8'h10}, 16, 1'b1, got);
    chk_chans();
    clk_en = 1'b1;
    repeat (2) @(negedge clk);
    send(8'h02, 8'h01);
    chk("after freeze", 32'h0000_0005, got);
    $display("test freeze done");
  endtask : t_freeze
  task automatic t_power();
    rst_n = 1'b0;
    repeat (12) @(negedge clk);
    rst_n = 1'b1;
    foreach (exp_ch[c])
      exp_ch[c] = CHAN_RESET;
    repeat (3) @(negedge clk);
    chk_chans();
    chk("dout after reset", 32'h0, {31'h0, ser_dout});
    $display("test power done");
  endtask : t_power
  task automatic t_repower();
    t_power();
    send(8'h01, 8'h20);
    chk("out after reset", 32'h0, got);
    $display("test repower done");
  endtask : t_repower
  task automatic end_sim();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : end_sim
  initial
  begin
    clk_en = 1'b1;
    t_power();
    t_taps();
    t_bad_addr();
    t_chain();
    t_held();
    t_freeze();
    t_repower();
    chk("latch pulses", 32'(n_frames), 32'(n_lat));
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
